// *** tsa_pkg.sv ***
// Package for the tributary slot allocator: frame geometry, slot counts
// and unit/mode encodings.
// Assumes a byte-wide, frame-aligned payload stream of 4 rows x 3824 cols.
package tsa_pkg;

  // ==========================================================
  // Frame geometry
  localparam int unsigned ROWS        = 4;
  localparam int unsigned COLS        = 3824;
  localparam logic [11:0] COL_OH_LO   = 12'hF;    // Overhead column 15
  localparam logic [11:0] COL_OH_HI   = 12'h10;   // Overhead column 16
  localparam logic [11:0] COL_PL_1ST  = 12'h11;   // First payload column 17
  localparam logic [11:0] COL_PL_L4_E = 12'hEE8;  // Column 3816
  localparam logic [11:0] COL_LAST    = 12'hEF0;  // Column 3824
  localparam logic [2:0]  ROW_OH_LAST = 3'h3;     // Overhead rows 1..3

  // ==========================================================
  // Slot counts per unit and mode
  localparam logic [6:0] NS_L1      = 7'h2;
  localparam logic [6:0] NS_L3_COARSE = 7'h10;
  localparam logic [6:0] NS_L3_FINE = 7'h20;
  localparam logic [6:0] NS_L4      = 7'h50;

  // Reset value of slot outputs
  localparam logic [6:0] SLOT_RST   = 7'h0;

  // ==========================================================
  // Payload unit selection
  typedef enum logic [1:0] {
    UNIT_L1,
    UNIT_L3,
    UNIT_L4
  } tsa_unit_t;

  // Level-3 slot size mode
  typedef enum logic {
    MODE_COARSE,
    MODE_FINE
  } tsa_mode_t;

endpackage : tsa_pkg

// *** tsa_mf_decode.sv ***
// Multiframe decoder: maps the multiframe counter/indicator byte to the
// slot number (1-based) owning the slot overhead of this frame.
// Assumes the byte is stable for the whole frame.
`timescale 1ns/1ns
module tsa_mf_decode (
  // Selection
  input  wire tsa_pkg::tsa_unit_t unit,
  input  wire tsa_pkg::tsa_mode_t mode,
  // Multiframe bytes, bit 1 = msb
  input  wire logic [7:0]         multiframe_counter_byte,
  input  wire logic [7:0]         multiframe_indicator_byte,
  // Slot that owns the overhead, 1-based
  output logic [6:0]              oh_slot
);

  // ==========================================================
  // Decode
  // Bit n of the byte (n=1 msb) is index 8-n.
  always_comb begin
    oh_slot = 7'h1;
    unique case (unit)
      tsa_pkg::UNIT_L1:
        oh_slot = {6'h0, multiframe_counter_byte[0]} + 7'h1;
      tsa_pkg::UNIT_L3: begin
        if (mode == tsa_pkg::MODE_FINE) begin
          oh_slot = {2'h0, multiframe_counter_byte[4:0]} + 7'h1;
        end else begin
          oh_slot = {3'h0, multiframe_counter_byte[3:0]} + 7'h1;
        end
      end
      tsa_pkg::UNIT_L4:
        oh_slot = multiframe_indicator_byte[6:0] + 7'h1;
      default: oh_slot = 7'h1;
    endcase
  end

endmodule : tsa_mf_decode

// *** tsa_top.sv ***
// Tributary slot allocator: tags each payload, overhead and stuff byte of a frame-aligned
// stream with its tributary slot, overhead ownership or fixed stuff.
// Assumes sof marks row 1 column 1 and byte_valid strobes each byte.
`timescale 1ns/1ns
module tsa_top (
  // Clock and reset
  input  wire logic               mclk,
  input  wire logic               reset_n,
  // Configuration
  input  wire tsa_pkg::tsa_unit_t unit,
  input  wire tsa_pkg::tsa_mode_t mode,
  // Framer stream
  input  wire logic               byte_valid,
  input  wire logic               sof,
  input  wire logic [7:0]         byte_in,
  input  wire logic [7:0]         multiframe_counter_byte,
  input  wire logic [7:0]         multiframe_indicator_byte,
  // Tagged stream to mappers/demappers
  output logic                    out_valid_ff,
  output logic [7:0]              out_byte_ff,
  output logic [6:0]              slot_fine_ff,
  output logic [6:0]              slot_coarse_ff,
  output logic                    payload_ff,
  output logic                    slot_overhead_ff,
  output logic [6:0]              oh_slot_ff,
  output logic                    fixed_stuff_ff,
  output logic                    mf_start_ff
);

  // ==========================================================
  // Position state
  logic [11:0] col_ff;         // Column of the next byte
  logic [11:0] nxt_col;
  logic [2:0]  row_ff;         // Row of the next byte
  logic [2:0]  nxt_row;
  logic        run_ff;         // Position known
  logic        nxt_run;

  // Slot state
  logic [6:0]  slot_ff;        // Next slot to hand out, 0-based
  logic [6:0]  nxt_slot;

  // Frame facts of the byte now offered
  logic [6:0]  nslots;         // Slots in the payload area
  logic [6:0]  slot_last;      // Highest slot index, 0-based
  logic [6:0]  oh_slot;        // Owner of this frame's overhead
  logic [6:0]  slot_base;      // Slot index of this byte, 0-based
  logic [11:0] cur_col;
  logic [2:0]  cur_row;
  logic        row_end;        // Byte closes its row
  logic        frame_end;      // Byte closes its frame
  logic        take;           // Byte accepted this cycle
  logic        is_pl;
  logic        is_oh;
  logic        is_fs;
  logic        mf_zero;        // Multiframe field reads zero
  logic        mf_first;

  // Tag shown when a byte belongs to no slot
  localparam logic [6:0] SLOT_NONE = tsa_pkg::SLOT_RST;

  // Outputs next values
  logic        nxt_out_valid;
  logic [7:0]  nxt_out_byte;
  logic [6:0]  nxt_slot_fine;
  logic [6:0]  nxt_slot_coarse;
  logic        nxt_payload;
  logic        nxt_slot_overhead;
  logic [6:0]  nxt_oh_slot;
  logic        nxt_fixed_stuff;
  logic        nxt_mf_start;

  // Overhead slot decode
  tsa_mf_decode u_dec (
    .unit                      (unit),
    .mode                      (mode),
    .multiframe_counter_byte   (multiframe_counter_byte),
    .multiframe_indicator_byte (multiframe_indicator_byte),
    .oh_slot                   (oh_slot)
  );

  // ==========================================================
  // Slot count per unit; coarse mode always allowed on level 3
  always_comb begin
    unique case (unit)
      tsa_pkg::UNIT_L1: begin
        nslots = tsa_pkg::NS_L1;
      end
      tsa_pkg::UNIT_L3: begin
        if (mode == tsa_pkg::MODE_FINE) begin
          nslots = tsa_pkg::NS_L3_FINE;
        end else begin
          nslots = tsa_pkg::NS_L3_COARSE;
        end
      end
      tsa_pkg::UNIT_L4: begin
        nslots = tsa_pkg::NS_L4;
      end
      default: begin
        nslots = tsa_pkg::NS_L4;
      end
    endcase
    slot_last = nslots - 7'h1;
  end

  // ==========================================================
  // Acceptance: bytes count only once a frame start was seen
  assign take = byte_valid && (run_ff || sof);

  // ==========================================================
  // Byte position: sof forces row 1 column 1
  always_comb begin
    if (sof) begin
      cur_col = 12'h1;
      cur_row = 3'h1;
    end else begin
      cur_col = col_ff;
      cur_row = row_ff;
    end
    row_end   = cur_col == tsa_pkg::COL_LAST;
    frame_end = row_end && (cur_row == 3'(tsa_pkg::ROWS));
  end

  // ==========================================================
  // Multiframe start: decoded field is zero on the frame start
  always_comb begin
    mf_zero = 1'b0;
    unique case (unit)
      tsa_pkg::UNIT_L1: begin
        mf_zero = multiframe_counter_byte[0] == 1'b0;
      end
      tsa_pkg::UNIT_L3: begin
        if (mode == tsa_pkg::MODE_FINE) begin
          mf_zero = multiframe_counter_byte[4:0] == 5'h0;
        end else begin
          mf_zero = multiframe_counter_byte[3:0] == 4'h0;
        end
      end
      tsa_pkg::UNIT_L4: begin
        mf_zero = multiframe_indicator_byte[6:0] == 7'h0;
      end
      default: begin
        mf_zero = 1'b0;
      end
    endcase
    mf_first = mf_zero && sof;
  end

  // ==========================================================
  // Byte class: overhead, level-4 fixed stuff or payload
  always_comb begin
    // Overhead bytes in rows 1..3, columns 15..16
    is_oh = (cur_row <= tsa_pkg::ROW_OH_LAST)
         && (cur_col == tsa_pkg::COL_OH_LO
          || cur_col == tsa_pkg::COL_OH_HI);
    // Level-4 stuff columns belong to no slot
    is_fs = (unit == tsa_pkg::UNIT_L4)
         && (cur_col > tsa_pkg::COL_PL_L4_E);
    // Payload from column 17 on, stuff excluded
    is_pl = (cur_col >= tsa_pkg::COL_PL_1ST) && !is_fs;
  end

  // ==========================================================
  // Slot of this byte; a multiframe start restarts at slot 1
  always_comb begin
    if (mf_first) begin
      slot_base = 7'h0;
    end else begin
      slot_base = slot_ff;
    end
  end

  // ==========================================================
  // Position next state: columns, then rows, wrap per frame
  always_comb begin
    nxt_col = col_ff;
    nxt_row = row_ff;
    nxt_run = run_ff;
    if (take) begin
      nxt_run = 1'b1;
      if (frame_end) begin
        nxt_col = 12'h1;
        nxt_row = 3'h1;
      end else if (row_end) begin
        nxt_col = 12'h1;
        nxt_row = cur_row + 3'h1;
      end else begin
        nxt_col = cur_col + 12'h1;
        nxt_row = cur_row;
      end
    end
  end

  // ==========================================================
  // Slot next state: steps on payload bytes only, cyclic 0..N-1,
  // carried across rows and frames
  always_comb begin
    nxt_slot = slot_ff;
    if (take) begin
      nxt_slot = slot_base;
      if (is_pl && slot_base == slot_last) begin
        nxt_slot = 7'h0;
      end else if (is_pl) begin
        nxt_slot = slot_base + 7'h1;
      end
    end
  end

  // ==========================================================
  // Stream outputs next values
  always_comb begin
    nxt_out_valid = take;
    nxt_out_byte  = byte_in;
  end

  // ==========================================================
  // Tag outputs next values
  always_comb begin
    nxt_payload       = take && is_pl;
    nxt_slot_overhead = take && is_oh;
    nxt_fixed_stuff   = take && is_fs;
    nxt_mf_start      = take && mf_first;
    nxt_oh_slot       = SLOT_NONE;
    nxt_slot_fine     = SLOT_NONE;
    nxt_slot_coarse   = SLOT_NONE;
    // Overhead owner shown only on overhead bytes
    if (nxt_slot_overhead) begin
      nxt_oh_slot = oh_slot;
    end
    // Payload bytes carry their 1-based slot
    if (nxt_payload) begin
      nxt_slot_fine   = slot_base + 7'h1;
      nxt_slot_coarse = nxt_slot_fine;
    end
    // Coarse slot i is carried by fine slots i and i+16
    if (nxt_payload && unit == tsa_pkg::UNIT_L3
        && mode == tsa_pkg::MODE_FINE
        && nxt_slot_fine > tsa_pkg::NS_L3_COARSE) begin
      nxt_slot_coarse = nxt_slot_fine - tsa_pkg::NS_L3_COARSE;
    end
  end

  // ==========================================================
  // Position registers
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      col_ff <= 12'h1;
      row_ff <= 3'h1;
      run_ff <= 1'b0;
    end else begin
      col_ff <= nxt_col;
      row_ff <= nxt_row;
      run_ff <= nxt_run;
    end
  end

  // Slot register
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      slot_ff <= 7'h0;
    end else begin
      slot_ff <= nxt_slot;
    end
  end

  // Stream output registers
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      out_valid_ff <= 1'b0;
      out_byte_ff  <= 8'h0;
    end else begin
      out_valid_ff <= nxt_out_valid;
      out_byte_ff  <= nxt_out_byte;
    end
  end

  // Tag output registers
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      slot_fine_ff     <= tsa_pkg::SLOT_RST;
      slot_coarse_ff   <= tsa_pkg::SLOT_RST;
      payload_ff       <= 1'b0;
      slot_overhead_ff <= 1'b0;
      oh_slot_ff       <= tsa_pkg::SLOT_RST;
      fixed_stuff_ff   <= 1'b0;
      mf_start_ff      <= 1'b0;
    end else begin
      slot_fine_ff     <= nxt_slot_fine;
      slot_coarse_ff   <= nxt_slot_coarse;
      payload_ff       <= nxt_payload;
      slot_overhead_ff <= nxt_slot_overhead;
      oh_slot_ff       <= nxt_oh_slot;
      fixed_stuff_ff   <= nxt_fixed_stuff;
      mf_start_ff      <= nxt_mf_start;
    end
  end

endmodule : tsa_top

// *** tsa_chk.sv ***
// Checker on the slot allocator top ports.
// Assumes unit, mode and multiframe bytes stay static per frame.
`timescale 1ns/1ns
module tsa_chk (
  // Clock and reset
  input wire logic               mclk,
  input wire logic               reset_n,
  // Framer stream
  input wire logic               byte_valid,
  input wire logic               sof,
  input wire tsa_pkg::tsa_unit_t unit,
  input wire tsa_pkg::tsa_mode_t mode,
  input wire logic [7:0]         byte_in,
  input wire logic [7:0]         multiframe_counter_byte,
  input wire logic [7:0]         multiframe_indicator_byte,
  // Tagged stream
  input wire logic               out_valid_ff,
  input wire logic               payload_ff,
  input wire logic               mf_start_ff,
  input wire logic               slot_overhead_ff,
  input wire logic               fixed_stuff_ff,
  input wire logic [7:0]         out_byte_ff,
  input wire logic [6:0]         slot_fine_ff,
  input wire logic [6:0]         slot_coarse_ff,
  input wire logic [6:0]         oh_slot_ff
);
  // ==========
  // Slot count and overhead field of this frame
  wire logic [6:0] n = unit == tsa_pkg::UNIT_L1 ? 7'h2 :
    unit != tsa_pkg::UNIT_L3 ? 7'h50 : mode ? 7'h20 : 7'h10;
  wire logic [6:0] f = n == 7'h2 ? {6'h0, multiframe_counter_byte[0]} :
    n == 7'h50 ? {1'h0, multiframe_indicator_byte[6:0]} :
    n == 7'h20 ? {2'h0, multiframe_counter_byte[4:0]} :
    {3'h0, multiframe_counter_byte[3:0]};
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);

  chk_first_col: assert property (reset_n && byte_valid && sof |=>
    out_valid_ff && !payload_ff && !slot_overhead_ff &&
    out_byte_ff == $past(byte_in)) else $error("first byte mistagged");
  chk_mf_start: assert property (reset_n && byte_valid && sof |=>
    mf_start_ff == ($past(f) == 7'h0)) else $error("multiframe start wrong");
  chk_oh_owner: assert property (slot_overhead_ff |->
    !payload_ff && oh_slot_ff == f + 7'h1) else $error("overhead owner wrong");
  chk_stuff_l4: assert property (fixed_stuff_ff |-> n == 7'h50 &&
    !payload_ff && slot_fine_ff == 7'h0) else $error("stuff byte wrong");
  chk_slot_range: assert property (payload_ff |->
    slot_fine_ff inside {[7'h1:n]}) else $error("slot out of range");
  chk_coarse_fold: assert property (payload_ff && n == 7'h20 |->
    slot_coarse_ff == slot_fine_ff - (slot_fine_ff > 7'h10 ? 7'h10 : 7'h0))
    else $error("coarse fold wrong");
  chk_coarse_same: assert property (payload_ff && n != 7'h20 |->
    slot_coarse_ff == slot_fine_ff) else $error("coarse slot differs");
  chk_slot_step: assert property (out_valid_ff && payload_ff ##1
    out_valid_ff && payload_ff |-> slot_fine_ff == ($past(slot_fine_ff) == n
    ? 7'h1 : $past(slot_fine_ff) + 7'h1)) else $error("slot step wrong");
endmodule : tsa_chk

bind tsa_top tsa_chk u_chk (.mclk, .reset_n, .byte_valid, .sof, .unit,
  .mode, .byte_in, .multiframe_counter_byte, .multiframe_indicator_byte,
  .out_valid_ff, .payload_ff, .mf_start_ff, .slot_overhead_ff,
  .fixed_stuff_ff, .out_byte_ff, .slot_fine_ff, .slot_coarse_ff, .oh_slot_ff);

// *** tsa_sink.sv ***
// Model of one slot mapper: counts the payload bytes it is handed.
// Assumes the tagged stream of the allocator, one byte per cycle.
`timescale 1ns/1ns
module tsa_sink (
  // Clock and control
  input  wire logic        mclk,
  input  wire logic        clear,
  // Tagged stream and watched slot
  input  wire logic        valid,
  input  wire logic        payload,
  input  wire logic [6:0]  slot,
  input  wire logic [6:0]  watch,
  // Bytes taken by the watched slot
  output logic [15:0]      count_ff
);
  // ==========
  // Take each payload byte addressed to the watched slot
  always_ff @(posedge mclk) begin
    if (clear) count_ff <= 16'h0;
    else if (valid && payload && slot == watch) count_ff <= count_ff + 16'h1;
  end
endmodule : tsa_sink

// *** tsa_tb.sv ***
// Self-checking bench for the slot allocator, a frame per unit and per level-3 mode.
// Assumes the allocator top, its bound checker and the sink model.
`timescale 1ns/1ns
module testbench;
  // ==========
  // Stimulus, observation and counters
  logic mclk = 1'h0, reset_n = 1'h0, byte_valid = 1'h0, sof = 1'h0;
  logic clr = 1'h1, ov, pl, oh, fs, mf;
  logic [7:0] byte_in = 8'h0, mcb = 8'h0, mib = 8'h0, ob;
  logic [6:0] sf, sc, os, watch = 7'h1;
  logic [15:0] cnt;
  tsa_pkg::tsa_unit_t unit = tsa_pkg::UNIT_L3;
  tsa_pkg::tsa_mode_t mode = tsa_pkg::MODE_FINE;
  int mismatches = 0;
  int total_checks = 0;
  always #20 mclk = ~mclk;

  tsa_top u_dut (.mclk, .reset_n, .unit, .mode, .byte_valid, .sof,
    .byte_in, .multiframe_counter_byte(mcb), .multiframe_indicator_byte(mib),
    .out_valid_ff(ov), .out_byte_ff(ob), .slot_fine_ff(sf),
    .slot_coarse_ff(sc), .payload_ff(pl), .slot_overhead_ff(oh),
    .oh_slot_ff(os), .fixed_stuff_ff(fs), .mf_start_ff(mf));
  tsa_sink u_sink (.mclk, .clear(clr), .valid(ov), .payload(pl), .slot(sf),
    .watch, .count_ff(cnt));

  // Compare and report
  task automatic cmp(input logic [33:0] got, exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : give_verdict

  // Expected tags of the byte at row r, column c
  function automatic logic [33:0] tag(int r, c, logic [7:0] mc, mi);
    int k, n, f, s;
    logic p, o;
    n = unit == tsa_pkg::UNIT_L1 ? 2 : unit == tsa_pkg::UNIT_L4 ? 80 :
      mode == tsa_pkg::MODE_FINE ? 32 : 16;
    k = n == 80 ? 3800 : 3808;
    f = n == 2 ? mc[0] : n == 80 ? mi[6:0] : n == 32 ? mc[4:0] : mc[3:0];
    p = c >= 17 && c < 17 + k;
    o = r < 3 && (c == 15 || c == 16);
    s = p ? (r * k + c - 17) % n + 1 : 0;
    tag = {1'h1, p, o, n == 80 && c > 3816, r == 0 && c == 1 && f == 0,
      7'(s), 7'(n == 32 && s > 16 ? s - 16 : s), 7'(o ? f + 1 : 0),
      8'(c ^ r)};
  endfunction : tag

  // Hold reset 20 cycles while selecting unit, mode and watched slot
  task automatic do_reset(input tsa_pkg::tsa_unit_t u,
    input tsa_pkg::tsa_mode_t m, input logic [6:0] w);
    @(negedge mclk);
    reset_n = 1'h0;
    clr = 1'h1;
    unit = u;
    mode = m;
    watch = w;
    repeat (20) @(negedge mclk);
    reset_n = 1'h1;
    clr = 1'h0;
  endtask : do_reset

  // Drive nb bytes of a frame and judge each tagged byte
  task automatic run_frame(input logic [7:0] mc, mi, input int nb);
    logic [33:0] e;
    e = 34'h0;
    for (int b = 0; b <= nb; b++) begin
      @(negedge mclk);
      if (b > 0) cmp({ov, pl, oh, fs, mf, sf, sc, os, ob}, e);
      e = tag(b / 3824, b % 3824 + 1, mc, mi);
      byte_valid = b < nb;
      sof = b == 0;
      byte_in = e[7:0];
      mcb = mc;
      mib = mi;
    end
  endtask : run_frame

  // Bytes before any frame start are refused
  task automatic sc_refuse;
    do_reset(tsa_pkg::UNIT_L3, tsa_pkg::MODE_FINE, 7'h1);
    byte_valid = 1'h1;
    repeat (4) begin
      @(negedge mclk);
      cmp(ov, 1'h0);
    end
    byte_valid = 1'h0;
  endtask : sc_refuse

  // Level-3 fine frame, then the top overhead owner
  task automatic sc_fine;
    do_reset(tsa_pkg::UNIT_L3, tsa_pkg::MODE_FINE, 7'h20);
    run_frame(8'hE0, 8'h0, 15296);
    @(negedge mclk);
    cmp(cnt, 16'(119 * 128 / 32));
    run_frame(8'h1F, 8'h0, 40);
  endtask : sc_fine

  // Level-3 coarse frame; bit 4 must not count
  task automatic sc_coarse;
    do_reset(tsa_pkg::UNIT_L3, tsa_pkg::MODE_COARSE, 7'h10);
    run_frame(8'hF0, 8'h0, 15296);
    @(negedge mclk);
    cmp(cnt, 16'(238 * 64 / 16));
    run_frame(8'h1F, 8'h0, 40);
  endtask : sc_coarse

  // Level-1 frame, then the second overhead owner
  task automatic sc_l1;
    do_reset(tsa_pkg::UNIT_L1, tsa_pkg::MODE_COARSE, 7'h2);
    run_frame(8'hFE, 8'h0, 15296);
    @(negedge mclk);
    cmp(cnt, 16'(1904 * 8 / 2));
    run_frame(8'h01, 8'h0, 40);
  endtask : sc_l1

  // Level-4 frame with stuff columns, then the last owner
  task automatic sc_l4;
    do_reset(tsa_pkg::UNIT_L4, tsa_pkg::MODE_COARSE, 7'h50);
    run_frame(8'h0, 8'h80, 15296);
    @(negedge mclk);
    cmp(cnt, 16'(95 * 160 / 80));
    run_frame(8'h0, 8'h4F, 40);
  endtask : sc_l4

  // Main sequence
  initial begin
    sc_refuse();
    sc_fine();
    sc_coarse();
    sc_l1();
    sc_l4();
    give_verdict();
  end
endmodule : testbench
